// ---- ddr_cmd_front.sv ----
// command and address front end of a single-rank x8 memory module
`timescale 1ns/1ps
module ddr_cmd_front (
   // core clock and reset
   input  wire logic                               clk_in,
   input  wire logic                               reset_in,
   // link clock, true phase of the differential pair
   input  wire logic                               link_ck_in,
   // command pins, link domain
   input  wire logic                               cke_in,
   input  wire logic                               cs_n_in,
   input  wire logic                               act_n_in,
   input  wire logic                               ras_n_in,
   input  wire logic                               cas_n_in,
   input  wire logic                               we_n_in,
   // address pins, link domain
   input  wire logic [ddr_cmd_pkg::GRP_W-1:0]      grp_in,
   input  wire logic [ddr_cmd_pkg::BNK_W-1:0]      bnk_in,
   input  wire logic [ddr_cmd_pkg::PIN_A_W-1:0]    addr_in,
   // mode register readback
   input  wire logic [ddr_cmd_pkg::MR_SEL_W-1:0]   mr_rd_sel_in,
   output logic      [ddr_cmd_pkg::MR_W-1:0]       mr_rd_data_out,
   // decoded command
   output logic                                    cmd_valid_out,
   output ddr_cmd_pkg::cmd_e                       cmd_kind_out,
   output logic      [ddr_cmd_pkg::GRP_W-1:0]      grp_out,
   output logic      [ddr_cmd_pkg::BNK_W-1:0]      bnk_out,
   output logic      [ddr_cmd_pkg::ROW_W-1:0]      row_out,
   output logic      [ddr_cmd_pkg::COL_W-1:0]      col_out,
   output logic                                    auto_pre_out,
   output logic                                    pre_all_out,
   output logic                                    burst8_out,
   output logic      [ddr_cmd_pkg::MR_SEL_W-1:0]   mr_index_out,
   output logic      [ddr_cmd_pkg::MR_W-1:0]       mr_code_out,
   // bank state
   output logic      [ddr_cmd_pkg::NBANK-1:0]      bank_open_out,
   output logic                                    closed_access_out
);
   localparam int BW = $clog2(ddr_cmd_pkg::NBANK);

   cmd_link_if link ();

   logic                               tog_s1;
   logic                               tog_s2;
   logic                               tog_s3;
   logic                               new_cmd;
   logic                               p1;
   ddr_cmd_pkg::cmd_e                  cur_kind;
   logic [ddr_cmd_pkg::GRP_W-1:0]      cur_grp;
   logic [ddr_cmd_pkg::BNK_W-1:0]      cur_bnk;
   logic [ddr_cmd_pkg::ADDR_W-1:0]     cur_addr;
   logic [BW-1:0]                      cur_bank;
   logic [ddr_cmd_pkg::MR_SEL_W-1:0]   mr_index;
   logic [ddr_cmd_pkg::ROW_W-1:0]      open_row;
   logic [1:0]                         burst_mode;
   logic [ddr_cmd_pkg::NBANK-1:0]      bank_open;
   logic                               is_rdwr;
   logic                               is_act;
   logic                               is_mrs;
   logic                               cur_ap;
   logic                               next_burst8;

   // pins are sampled on the link clock only
   cmd_capture u_capture (
      .link_ck_in (link_ck_in),
      .reset_in   (reset_in),
      .cke_in     (cke_in),
      .cs_n_in    (cs_n_in),
      .act_n_in   (act_n_in),
      .ras_n_in   (ras_n_in),
      .cas_n_in   (cas_n_in),
      .we_n_in    (we_n_in),
      .grp_in     (grp_in),
      .bnk_in     (bnk_in),
      .addr_in    (addr_in),
      .lnk        (link.cap)
   );

   // toggle crossing; captured fields stay put one link period,
   // so the core clock must run at least three times the link clock
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         tog_s3 <= 1'b0;
      end else begin
         tog_s1 <= link.tog;
         tog_s2 <= tog_s1;
         tog_s3 <= tog_s2;
      end
   end

   assign new_cmd = tog_s2 ^ tog_s3;

   // stage one: hold the command while the row store is read
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cur_kind <= ddr_cmd_pkg::CMD_NONE;
         cur_grp  <= 2'h0;
         cur_bnk  <= 2'h0;
         cur_addr <= 17'h0;
      end else if (new_cmd) begin
         cur_kind <= link.kind;
         cur_grp  <= link.grp;
         cur_bnk  <= link.bnk;
         cur_addr <= link.addr;
      end
   end

   // stage one valid flag
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         p1 <= 1'b0;
      end else begin
         p1 <= new_cmd;
      end
   end

   // four groups of four banks, group in the upper index bits
   assign cur_bank = {cur_grp, cur_bnk}; // [R10] [R11]
   // mode register number from group bit 0 and bank bits
   assign mr_index = {cur_grp[0], cur_bnk}; // [R8]
   assign is_rdwr  = (cur_kind == ddr_cmd_pkg::CMD_RD) || (cur_kind == ddr_cmd_pkg::CMD_WR);
   assign is_act   = (cur_kind == ddr_cmd_pkg::CMD_ACT);
   assign is_mrs   = (cur_kind == ddr_cmd_pkg::CMD_MRS);
   assign cur_ap   = cur_addr[ddr_cmd_pkg::AP_BIT];

   // open row of each bank, written on activate, read per access
   word_mem #(
      .WIDTH (ddr_cmd_pkg::ROW_W),
      .DEPTH (ddr_cmd_pkg::NBANK)
   ) u_rows (
      .clk_in      (clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (p1 && is_act), // [R1]
      .wr_addr_in  (cur_bank),
      .wr_data_in  (cur_addr[ddr_cmd_pkg::ROW_W-1:0]),
      .rd_addr_in  ({link.grp, link.bnk}),
      .rd_data_out (open_row)
   );

   // mode register contents, readable by the user side
   word_mem #(
      .WIDTH (ddr_cmd_pkg::MR_W),
      .DEPTH (ddr_cmd_pkg::NMR)
   ) u_modes (
      .clk_in      (clk_in),
      .reset_in    (reset_in),
      .wr_en_in    (p1 && is_mrs), // [R2] [R8]
      .wr_addr_in  (mr_index),
      .wr_data_in  (cur_addr[ddr_cmd_pkg::MR_W-1:0]),
      .rd_addr_in  (mr_rd_sel_in),
      .rd_data_out (mr_rd_data_out)
   );

   // burst field kept apart so decode needs no memory read
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         burst_mode <= ddr_cmd_pkg::BURST_BL8;
      end else if (p1 && is_mrs && mr_index == ddr_cmd_pkg::MR_BURST_SEL) begin
         burst_mode <= cur_addr[ddr_cmd_pkg::BURST_LSB +: 2]; // [R6]
      end
   end

   // burst length of this access; reserved mode code acts as length 8
   always_comb begin
      unique case (burst_mode)
         ddr_cmd_pkg::BURST_OTF: next_burst8 = cur_addr[ddr_cmd_pkg::BC_BIT]; // [R5]
         ddr_cmd_pkg::BURST_BC4: next_burst8 = 1'b0; // [R6]
         default:                next_burst8 = 1'b1;
      endcase
   end

   // bank open state; auto precharge closes the bank at the access
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         bank_open <= 16'h0;
      end else if (p1) begin
         unique case (cur_kind)
            ddr_cmd_pkg::CMD_ACT: bank_open[cur_bank] <= 1'b1; // [R1]
            ddr_cmd_pkg::CMD_RD,
            ddr_cmd_pkg::CMD_WR: begin
               if (cur_ap) begin
                  bank_open[cur_bank] <= 1'b0; // [R3]
               end
            end
            ddr_cmd_pkg::CMD_PRE: begin
               if (cur_ap) begin
                  bank_open <= 16'h0; // [R4]
               end else begin
                  bank_open[cur_bank] <= 1'b0; // [R4]
               end
            end
            ddr_cmd_pkg::CMD_NONE,
            ddr_cmd_pkg::CMD_REF,
            ddr_cmd_pkg::CMD_MRS: ;
         endcase
      end
   end

   assign bank_open_out = bank_open;

   // one-cycle command strobe
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cmd_valid_out <= 1'b0;
      end else begin
         cmd_valid_out <= p1;
      end
   end

   // decoded fields, held until the next command
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cmd_kind_out      <= ddr_cmd_pkg::CMD_NONE;
         grp_out           <= 2'h0;
         bnk_out           <= 2'h0;
         row_out           <= 15'h0;
         col_out           <= 10'h0;
         auto_pre_out      <= 1'b0;
         pre_all_out       <= 1'b0;
         burst8_out        <= 1'b0;
         mr_index_out      <= 3'h0;
         mr_code_out       <= 14'h0;
         closed_access_out <= 1'b0;
      end else if (p1) begin
         cmd_kind_out <= cur_kind;
         grp_out      <= cur_grp; // [R9]
         bnk_out      <= cur_bnk; // [R8]
         // access reports the row opened earlier in that bank
         row_out      <= is_act ? cur_addr[ddr_cmd_pkg::ROW_W-1:0] : open_row; // [R1]
         col_out      <= cur_addr[ddr_cmd_pkg::COL_W-1:0]; // [R1]
         auto_pre_out <= is_rdwr && cur_ap; // [R3]
         pre_all_out  <= (cur_kind == ddr_cmd_pkg::CMD_PRE) && cur_ap; // [R4]
         burst8_out   <= is_rdwr && next_burst8; // [R5]
         mr_index_out <= mr_index; // [R2]
         mr_code_out  <= is_mrs ? cur_addr[ddr_cmd_pkg::MR_W-1:0] : 14'h0; // [R2]
         // access to a bank with no open row is flagged, not dropped
         closed_access_out <= is_rdwr && !bank_open[cur_bank];
      end
   end

   default clocking cb_core @(posedge clk_in); endclocking
   default disable iff (reset_in);

   chk_cmd_latency: assert property ( // [R13]
      new_cmd |-> ##2 cmd_valid_out)
      else $error("command strobe not two cycles after crossing");
   chk_act_opens: assert property ( // [R1]
      p1 && is_act |=> bank_open[$past(cur_bank)] && cmd_valid_out)
      else $error("activate did not open the bank");
   chk_act_row: assert property ( // [R7]
      p1 && is_act |=> row_out == $past(cur_addr[ddr_cmd_pkg::ROW_W-1:0]))
      else $error("activate row not reported");
   chk_col_out: assert property ( // [R1]
      p1 && is_rdwr |=> col_out == $past(cur_addr[ddr_cmd_pkg::COL_W-1:0]))
      else $error("column address not reported");
   chk_mrs_code: assert property ( // [R2]
      p1 && is_mrs |=> mr_code_out == $past(cur_addr[ddr_cmd_pkg::MR_W-1:0])
         && mr_index_out == $past(mr_index))
      else $error("mode register op-code not reported");
   chk_auto_pre: assert property ( // [R3]
      p1 && is_rdwr && cur_ap |=> auto_pre_out && !bank_open[$past(cur_bank)])
      else $error("auto precharge not applied");
   chk_no_auto_pre: assert property ( // [R3]
      p1 && is_rdwr && !cur_ap |=> !auto_pre_out && $stable(bank_open))
      else $error("bank closed without auto precharge");
   chk_pre_all: assert property ( // [R4]
      p1 && cur_kind == ddr_cmd_pkg::CMD_PRE && cur_ap |=> bank_open == 16'h0 && pre_all_out)
      else $error("precharge all left a bank open");
   chk_pre_one: assert property ( // [R4]
      p1 && cur_kind == ddr_cmd_pkg::CMD_PRE && !cur_ap |=>
         bank_open == ($past(bank_open) & ~(16'h1 << $past(cur_bank))))
      else $error("single precharge touched the wrong banks");
   chk_burst_otf: assert property ( // [R5]
      p1 && is_rdwr && burst_mode == ddr_cmd_pkg::BURST_OTF |=>
         burst8_out == $past(cur_addr[ddr_cmd_pkg::BC_BIT]))
      else $error("on-the-fly burst chop not followed");
   chk_burst_fixed: assert property ( // [R6]
      p1 && is_rdwr && burst_mode == ddr_cmd_pkg::BURST_BC4 |=> !burst8_out)
      else $error("fixed chop mode gave a full burst");
   chk_group_out: assert property ( // [R9]
      p1 |=> {grp_out, bnk_out} == $past(cur_bank))
      else $error("bank group or bank not reported");
   chk_closed_flag: assert property ( // [R11]
      p1 && is_rdwr |=> closed_access_out == !$past(bank_open[cur_bank]))
      else $error("access to a closed bank not flagged");
   chk_held_fields: assert property ( // [R13]
      !p1 |=> $stable(cmd_kind_out) && $stable(row_out) && $stable(col_out))
      else $error("decoded fields moved without a command");
   chk_burst_full: assert property ( // [R6]
      p1 && is_rdwr && burst_mode == ddr_cmd_pkg::BURST_BL8 |=> burst8_out)
      else $error("fixed length 8 mode gave a chopped burst");
   chk_ref_keeps: assert property ( // [R9]
      p1 && cur_kind == ddr_cmd_pkg::CMD_REF |=> $stable(bank_open) && !closed_access_out)
      else $error("refresh changed the bank state");

   cov_act: cover property (p1 && is_act);
   cov_rd_autopre: cover property (p1 && cur_kind == ddr_cmd_pkg::CMD_RD && cur_ap);
   cov_mrs: cover property (p1 && is_mrs);
   cov_pre_all: cover property (p1 && cur_kind == ddr_cmd_pkg::CMD_PRE && cur_ap);
   cov_chop_otf: cover property (p1 && is_rdwr && burst_mode == ddr_cmd_pkg::BURST_OTF
      && !next_burst8);
endmodule : ddr_cmd_front

// ---- ddr_cmd_pkg.sv ----
// shared constants and types for the command and address front end
// Contract
// R1: the controller gives the row address with ACTIVATE and the column address with READ and WRITE, which pick one location in the addressed bank.
// R2: a MODE REGISTER SET takes its op-code for the selected mode register from the address pins.
// R3: A10 taken with READ or WRITE asks for auto precharge of the accessed bank when high.
// R4: a PRECHARGE closes only the addressed bank when A10 is low and every bank when it is high.
// R5: A12 taken with READ or WRITE chops the burst when low and keeps the full burst when high.
// R6: the mode registers fix the burst at chop 4 or length 8, or leave it to be chosen per command.
// R7: ACT_n low with chip select marks ACTIVATE, and then RAS_n, CAS_n and WE_n are row bits A16, A15, A14.
// R8: bank address picks the bank inside the group and, with the bank group, picks the mode register written.
// R9: bank group picks the target group for REFRESH, ACTIVATE, READ, WRITE and PRECHARGE.
// R10: both bank group bits are decoded, giving four groups.
// R11: storage is sixteen banks, four groups of four banks.
// R12: the controller never relies on A17, which means nothing for these x8 parts.
// R13: every command, address and control pin is taken on the rising edge of the true clock.
// R14: at a 0.83 ns clock the controller uses CL 16 and 16 clocks for activate-to-command and precharge, slower grades 15 and 13.
// R15: a command is ignored on any edge where chip select is sampled high.
// R16: the controller holds clock enable high through whole read and write accesses.
package ddr_cmd_pkg;
   // field widths
   localparam int ROW_W    = 15;
   localparam int COL_W    = 10;
   localparam int GRP_W    = 2;
   localparam int BNK_W    = 2;
   localparam int PIN_A_W  = 14;
   localparam int ADDR_W   = 17;
   localparam int MR_W     = 14;
   localparam int MR_SEL_W = 3;
   localparam int NBANK    = 16;
   localparam int NMR      = 8;
   // address bits with a second job
   localparam int AP_BIT   = 10;
   localparam int BC_BIT   = 12;
   // pin code {ras_n, cas_n, we_n} while act_n is high
   localparam logic [2:0] CODE_MRS = 3'h0;
   localparam logic [2:0] CODE_REF = 3'h1;
   localparam logic [2:0] CODE_PRE = 3'h2;
   localparam logic [2:0] CODE_WR  = 3'h4;
   localparam logic [2:0] CODE_RD  = 3'h5;
   // burst field of mode register 0
   localparam logic [MR_SEL_W-1:0] MR_BURST_SEL = 3'h0;
   localparam int                  BURST_LSB    = 0;
   localparam logic [1:0]          BURST_BL8    = 2'h0;
   localparam logic [1:0]          BURST_OTF    = 2'h1;
   localparam logic [1:0]          BURST_BC4    = 2'h2;
   // latency figures per grade, used by the controller only
   localparam int CL_FAST = 16;
   localparam int CL_MID  = 15;
   localparam int CL_SLOW = 13;
   // decoded command kinds
   typedef enum logic [2:0] {
      CMD_NONE, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
   } cmd_e;
endpackage : ddr_cmd_pkg

// ---- cmd_link_if.sv ----
// decoded command carried from the link domain to the core domain
`timescale 1ns/1ps
interface cmd_link_if;
   logic                           tog;
   ddr_cmd_pkg::cmd_e              kind;
   logic [ddr_cmd_pkg::GRP_W-1:0]  grp;
   logic [ddr_cmd_pkg::BNK_W-1:0]  bnk;
   logic [ddr_cmd_pkg::ADDR_W-1:0] addr;
   modport cap  (output tog, kind, grp, bnk, addr);
   modport core (input tog, kind, grp, bnk, addr);
endinterface : cmd_link_if

// ---- word_mem.sv ----
// small word memory with registered read data
`timescale 1ns/1ps
module word_mem #(
   parameter int  WIDTH = 8,
   parameter int  DEPTH = 8,
   localparam int AW    = $clog2(DEPTH)
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // write port
   input  wire logic             wr_en_in,
   input  wire logic [AW-1:0]    wr_addr_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   // read port
   input  wire logic [AW-1:0]    rd_addr_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem [DEPTH];

   // array has no reset: a word never written reads unknown
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // read data always from a flop
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         rd_data_out <= {WIDTH{1'b0}};
      end else begin
         rd_data_out <= mem[rd_addr_in];
      end
   end
endmodule : word_mem

// ---- cmd_capture.sv ----
// link-side sampling and decode of the command and address pins
`timescale 1ns/1ps
module cmd_capture (
   // link clock and reset
   input  wire logic                              link_ck_in,
   input  wire logic                              reset_in,
   // command pins
   input  wire logic                              cke_in,
   input  wire logic                              cs_n_in,
   input  wire logic                              act_n_in,
   input  wire logic                              ras_n_in,
   input  wire logic                              cas_n_in,
   input  wire logic                              we_n_in,
   // address pins
   input  wire logic [ddr_cmd_pkg::GRP_W-1:0]     grp_in,
   input  wire logic [ddr_cmd_pkg::BNK_W-1:0]     bnk_in,
   input  wire logic [ddr_cmd_pkg::PIN_A_W-1:0]   addr_in,
   // decoded command toward the core
   cmd_link_if.cap                                lnk
);
   logic              rst_s1;
   logic              link_rst;
   ddr_cmd_pkg::cmd_e next_kind;

   // reset asserts at once, releases on the link clock
   always_ff @(posedge link_ck_in or posedge reset_in) begin
      if (reset_in) begin
         rst_s1   <= 1'b1;
         link_rst <= 1'b1;
      end else begin
         rst_s1   <= 1'b0;
         link_rst <= rst_s1;
      end
   end

   // decode; masked when deselected or clock disabled
   always_comb begin
      next_kind = ddr_cmd_pkg::CMD_NONE;
      if (cke_in && !cs_n_in) begin // [R15]
         if (!act_n_in) begin
            next_kind = ddr_cmd_pkg::CMD_ACT; // [R7]
         end else begin
            case ({ras_n_in, cas_n_in, we_n_in})
               ddr_cmd_pkg::CODE_MRS: next_kind = ddr_cmd_pkg::CMD_MRS;
               ddr_cmd_pkg::CODE_REF: next_kind = ddr_cmd_pkg::CMD_REF;
               ddr_cmd_pkg::CODE_PRE: next_kind = ddr_cmd_pkg::CMD_PRE;
               ddr_cmd_pkg::CODE_WR:  next_kind = ddr_cmd_pkg::CMD_WR;
               ddr_cmd_pkg::CODE_RD:  next_kind = ddr_cmd_pkg::CMD_RD;
               default:               next_kind = ddr_cmd_pkg::CMD_NONE;
            endcase
         end
      end
   end

   // pins taken on the true clock rising edge, held for the core
   always_ff @(posedge link_ck_in or posedge link_rst) begin
      if (link_rst) begin
         lnk.tog  <= 1'b0;
         lnk.kind <= ddr_cmd_pkg::CMD_NONE;
         lnk.grp  <= 2'h0;
         lnk.bnk  <= 2'h0;
         lnk.addr <= 17'h0;
      end else if (next_kind != ddr_cmd_pkg::CMD_NONE) begin // [R13]
         lnk.kind <= next_kind;
         lnk.grp  <= grp_in; // [R9] [R10]
         lnk.bnk  <= bnk_in; // [R8]
         // top three bits are A16..A14 only under ACTIVATE; no A17 pin
         lnk.addr <= {ras_n_in, cas_n_in, we_n_in, addr_in}; // [R7] [R12]
         lnk.tog  <= ~lnk.tog;
      end
   end

   default clocking cb_link @(posedge link_ck_in); endclocking
   default disable iff (link_rst);

   chk_act_decode: assert property ( // [R7]
      cke_in && !cs_n_in && !act_n_in |=> lnk.kind == ddr_cmd_pkg::CMD_ACT
         && lnk.addr[16:14] == $past({ras_n_in, cas_n_in, we_n_in}))
      else $error("activate row bits not taken from command pins");
   chk_cs_masks: assert property ( // [R15]
      cs_n_in |=> $stable(lnk.tog))
      else $error("command taken while chip select high");
   chk_group_capture: assert property ( // [R9]
      next_kind != ddr_cmd_pkg::CMD_NONE |=> lnk.grp == $past(grp_in)
         && lnk.bnk == $past(bnk_in))
      else $error("bank group or bank not captured");
endmodule : cmd_capture

// ---- host_cmd_model.sv ----
// host controller model driving the command and address pins
`timescale 1ns/1ps
module host_cmd_model (
   // link clock
   input  wire logic        link_ck_in,
   // command and address pins
   output logic             cke_out,
   output logic             cs_n_out,
   output logic             act_n_out,
   output logic [2:0]       code_out,
   output logic [1:0]       grp_out,
   output logic [1:0]       bnk_out,
   output logic [13:0]      addr_out
);
   // fastest grade spacing after activate or precharge; the block checks none
   localparam int cas_lat = ddr_cmd_pkg::CL_FAST;
   int            gap     = 0;

   // idle bus: deselected, clock enable high
   initial begin
      cke_out   = 1'b1;
      cs_n_out  = 1'b1;
      act_n_out = 1'b1;
      code_out  = 3'h7;
      grp_out   = 2'h0;
      bnk_out   = 2'h0;
      addr_out  = 14'h0; // no a17 pin at all
   end

   // one command, launched after an edge and held across the next one
   task automatic issue(input logic cke, input logic cs_n, input logic act_n,
                        input logic [2:0] code, input logic [1:0] g,
                        input logic [1:0] b, input logic [13:0] a);
      repeat (gap) @(posedge link_ck_in);
      @(posedge link_ck_in);
      #1;
      cke_out   = cke;
      cs_n_out  = cs_n;
      act_n_out = act_n; // row bits ride on code pins when low
      code_out  = code;
      grp_out   = g;
      bnk_out   = b;
      addr_out  = a; // row, column or op-code
      gap       = (!act_n || code == ddr_cmd_pkg::CODE_PRE) ? cas_lat : 0;
      @(posedge link_ck_in); // sampled here
      #1;
      cke_out   = 1'b1;
      cs_n_out  = 1'b1;
      // stale lines flip so nothing reads an old value by luck
      act_n_out = ~act_n_out;
      code_out  = ~code_out;
      grp_out   = ~grp_out;
      bnk_out   = ~bnk_out;
      addr_out  = ~addr_out;
   endtask : issue
endmodule : host_cmd_model

// ---- ddr_cmd_front_tb_top.sv ----
// self-checking bench for the command and address front end
`timescale 1ns/1ps
module ddr_cmd_front_tb_top;
   logic              clk_in = 1'b0;
   logic              link_ck = 1'b0;
   logic              reset_in = 1'b1;
   logic              cke, cs_n, act_n, cmd_valid, auto_pre, pre_all, burst8, closed;
   logic [2:0]        code, mr_idx;
   logic [2:0]        mr_rd_sel = 3'h0;
   logic [1:0]        grp, bnk, grp_o, bnk_o;
   logic [13:0]       addr, mr_rd_data, mr_code;
   logic [14:0]       row_o;
   logic [9:0]        col_o;
   logic [15:0]       open_o, e_open;
   ddr_cmd_pkg::cmd_e kind;
   int                mismatches = 0, checked = 0, mode = 0;
   int                row_ref[16] = '{default: -1};

   // core clock; link clock unrelated in phase and free running
   always #12.5 clk_in = ~clk_in;
   initial begin
      #7.3;
      forever #62.5 link_ck = ~link_ck;
   end

   host_cmd_model host (.link_ck_in(link_ck), .cke_out(cke), .cs_n_out(cs_n),
      .act_n_out(act_n), .code_out(code), .grp_out(grp), .bnk_out(bnk), .addr_out(addr));

   ddr_cmd_front DUT (.clk_in(clk_in), .reset_in(reset_in), .link_ck_in(link_ck),
      .cke_in(cke), .cs_n_in(cs_n), .act_n_in(act_n), .ras_n_in(code[2]),
      .cas_n_in(code[1]), .we_n_in(code[0]), .grp_in(grp), .bnk_in(bnk), .addr_in(addr),
      .mr_rd_sel_in(mr_rd_sel), .mr_rd_data_out(mr_rd_data), .cmd_valid_out(cmd_valid),
      .cmd_kind_out(kind), .grp_out(grp_o), .bnk_out(bnk_o), .row_out(row_o),
      .col_out(col_o), .auto_pre_out(auto_pre), .pre_all_out(pre_all),
      .burst8_out(burst8), .mr_index_out(mr_idx), .mr_code_out(mr_code),
      .bank_open_out(open_o), .closed_access_out(closed));

   // one comparison, four-state exact
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // verdict and end of run
   task automatic end_sim;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // sel 0..5 act rd wr pre ref mrs; 6 deselected, 7 clock enable low, 8 bad code
   task automatic send(input int sel, input logic [1:0] g, input logic [1:0] b,
                       input logic [13:0] a);
      int         i;
      logic [2:0] c;
      logic       e_b8, e_ap, e_pa;
      logic [13:0] e_code;
      c = 3'($urandom);
      e_b8 = 1'b0;
      e_ap = 1'b0;
      e_pa = 1'b0;
      e_code = 14'h0;
      case (sel)
         1: c = ddr_cmd_pkg::CODE_RD;
         2: c = ddr_cmd_pkg::CODE_WR;
         3: c = ddr_cmd_pkg::CODE_PRE;
         4: c = ddr_cmd_pkg::CODE_REF;
         5: c = ddr_cmd_pkg::CODE_MRS;
         8: c = c[1] ? (3'h6 | {2'h0, c[0]}) : 3'h3;
         default: ;
      endcase
      host.issue(sel != 7, sel == 6, sel != 0, c, g, b, a);
      for (i = 0; i < 16 && cmd_valid !== 1'b1; i++) begin
         @(posedge clk_in);
         #1;
      end
      if (sel > 5) begin
         chk("refused", cmd_valid, 1'b0);
         return;
      end
      chk("valid", cmd_valid, 1'b1);
      chk("kind", kind, 32'(sel + 1));
      i = int'({g, b});
      if (sel != 5) chk("grp", grp_o, g);
      if (sel < 4) chk("bnk", bnk_o, b);
      case (sel)
         0: begin
            chk("row", row_o, {c[0], a});
            row_ref[i] = int'({c[0], a});
            e_open[i] = 1'b1;
         end
         1, 2: begin
            e_ap = a[ddr_cmd_pkg::AP_BIT];
            e_b8 = (mode == 2) ? 1'b0 : (mode == 1) ? a[ddr_cmd_pkg::BC_BIT] : 1'b1;
            chk("col", col_o, a[9:0]);
            chk("closed", closed, !e_open[i]);
            if (row_ref[i] >= 0) chk("row", row_o, row_ref[i]);
            if (e_ap) e_open[i] = 1'b0;
         end
         3: begin
            e_pa = a[ddr_cmd_pkg::AP_BIT];
            if (e_pa) e_open = 16'h0;
            else e_open[i] = 1'b0;
         end
         5: begin
            e_code = a;
            chk("mr_idx", mr_idx, {g[0], b});
            if ({g[0], b} == 3'h0) mode = int'(a[1:0]);
            mr_rd_sel = {g[0], b};
            @(posedge clk_in);
            @(posedge clk_in);
            #1;
            chk("mr_data", mr_rd_data, a);
         end
         default: ;
      endcase
      chk("auto_pre", auto_pre, e_ap);
      chk("burst8", burst8, e_b8);
      chk("pre_all", pre_all, e_pa);
      chk("mr_code", mr_code, e_code);
      chk("open", open_o, e_open);
   endtask : send

   // main sequence: reset, then each burst mode under random traffic
   initial begin
      e_open = 16'h0;
      mode = $urandom(32'h9b2303e1);
      mode = 0;
      repeat (12) @(posedge clk_in);
      #1;
      chk("rst_valid", cmd_valid, 1'b0);
      chk("rst_kind", kind, ddr_cmd_pkg::CMD_NONE);
      chk("rst_open", open_o, 16'h0);
      chk("rst_mr", mr_rd_data, 14'h0);
      reset_in = 1'b0;
      repeat (4) @(posedge link_ck);
      for (int m = 0; m < 4; m++) begin
         send(5, 2'($urandom) & 2'h2, 2'h0, {12'($urandom), 2'(m)});
         repeat (40) send($urandom_range(8, 0), 2'($urandom), 2'($urandom), 14'($urandom));
      end
      end_sim();
   end

   // watchdog well past the expected run length
   initial begin
      #500000;
      mismatches++;
      end_sim();
   end
endmodule : ddr_cmd_front_tb_top
